/* File: verilog/led_sink_pkg.sv */
// Purpose: shared constants and types for the LED sink blink/dim register bank
// Assumes: 250 MHz MCLK; blink times counted in 1 ms ticks
// Notes: register offsets are byte addresses of the register port
//
// Contract
// - Dim code is seven low bits; applied as backlight current after dim timeout.
// - Fade law select sits in bits 1:0; bits 7:2 reserved, read zero.
// - Law 00 linear DAC linear steps; law 01 square DAC linear steps.
// - Laws 10 and 11 use square DAC with nonlinear time steps.
// - Cubic laws keep square DAC value; only step timing varies.
// - Seven enable bits, sink one at bit 0; 1 on, 0 off; bit 7 reserved.
// - Shared on time in bits 7:6: 0.2, 0.6, 0.8, 1.2 seconds.
// - Enabled sink with nonzero off time stays on for on time, then off.
// - Then off for its off time, on again, alternating while enabled.
// - Off time 00 disables blinking; sink stays on while enabled.
// - Sink seven off time at bits 5:4: 0.6, 1.2, 1.8 seconds.
// - Sink six off time bits 3:2, sink five bits 1:0, same coding.
package led_sink_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_DIM_CURRENT = 8'h0A;
    localparam logic [7:0] ADDR_FADE_LAW = 8'h0F;
    localparam logic [7:0] ADDR_SINK_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_BLINK_TIME_A = 8'h11;

    localparam int DIM_CODE_MSB = 6;
    localparam int LAW_MSB = 1;
    localparam int ENABLE_MSB = 6;
    localparam int ON_TIME_LSB = 6;
    localparam int SEVEN_OFF_LSB = 4;
    localparam int SIX_OFF_LSB = 2;
    localparam int FIVE_OFF_LSB = 0;

    localparam logic [7:0] DIM_CURRENT_RST = 8'h00;
    localparam logic [7:0] FADE_LAW_RST = 8'h00;
    localparam logic [7:0] SINK_ENABLE_RST = 8'h00;
    localparam logic [7:0] BLINK_TIME_RST = 8'h00;

    localparam int NUM_SINKS = 7;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS * 1000 / CLK_PERIOD_PS;

    localparam logic [10:0] ON_MS_0 = 11'd200;
    localparam logic [10:0] ON_MS_1 = 11'd600;
    localparam logic [10:0] ON_MS_2 = 11'd800;
    localparam logic [10:0] ON_MS_3 = 11'd1200;
    localparam logic [10:0] OFF_MS_1 = 11'd600;
    localparam logic [10:0] OFF_MS_2 = 11'd1200;
    localparam logic [10:0] OFF_MS_3 = 11'd1800;

    typedef enum logic [1:0] {
        LAW_LINEAR,
        LAW_SQUARE,
        LAW_CUBIC_10,
        LAW_CUBIC_11
    } fade_law_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic square_dac;
        logic nonlinear_step;
        logic cubic_variant;
    } law_ctrl_t;

    function automatic logic [10:0] on_ms(input logic [1:0] code);
        case (code)
            2'h0: on_ms = ON_MS_0;
            2'h1: on_ms = ON_MS_1;
            2'h2: on_ms = ON_MS_2;
            default: on_ms = ON_MS_3;
        endcase
    endfunction : on_ms

    function automatic logic [10:0] off_ms(input logic [1:0] code);
        case (code)
            2'h1: off_ms = OFF_MS_1;
            2'h2: off_ms = OFF_MS_2;
            default: off_ms = OFF_MS_3;
        endcase
    endfunction : off_ms

endpackage : led_sink_pkg

/* File: verilog/tick_divider.sv */
// Purpose: one-cycle enable pulse every COUNT clocks
// Assumes: synchronous active-low reset
// Notes: free running; feeds the blink timers
`timescale 1ns/1ps
module tick_divider #(
    parameter int COUNT = 250000
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    localparam int W = $clog2(COUNT);
    localparam logic [W-1:0] LAST = W'(COUNT - 1);

    if (COUNT < 2) begin : g_bad_count
        $error("tick_divider COUNT must be at least 2");
    end

    logic [W-1:0] cnt_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (cnt_q == LAST);
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        end
    end
endmodule : tick_divider

/* File: verilog/sink_blinker.sv */
// Purpose: on/off blink sequencer for one current sink
// Assumes: tick is a 1 ms enable pulse
// Notes: first tick of a phase may be partial, so phases run up to 1 ms short
`timescale 1ns/1ps
module sink_blinker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic enable,
    input wire logic [1:0] on_code,
    input wire logic [1:0] off_code,
    output logic sink_on
);
    import led_sink_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ON,
        ST_OFF
    } blink_state_t;

    blink_state_t state_q;
    logic [10:0] cnt_q;
    logic [10:0] on_len;
    logic [10:0] off_len;

    assign on_len = on_ms(on_code);
    assign off_len = off_ms(off_code);
    assign sink_on = (state_q == ST_ON);

    // ****************************************
    // phase sequencer
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
        end else if (!enable) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
        end else if (off_code == 2'h0) begin
            state_q <= ST_ON;
            cnt_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_q <= ST_ON;
                    cnt_q <= '0;
                end
                ST_ON: begin
                    if (tick) begin
                        if (cnt_q + 11'd1 >= on_len) begin
                            state_q <= ST_OFF;
                            cnt_q <= '0;
                        end else begin
                            cnt_q <= cnt_q + 11'd1;
                        end
                    end
                end
                ST_OFF: begin
                    if (tick) begin
                        if (cnt_q + 11'd1 >= off_len) begin
                            state_q <= ST_ON;
                            cnt_q <= '0;
                        end else begin
                            cnt_q <= cnt_q + 11'd1;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    cnt_q <= '0;
                end
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_blink_start_on: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(enable) && off_code != 2'h0 |=> state_q == ST_ON)
        else $error("blink did not start in on phase");
    a_steady_on_mode: assert property (@(posedge clk) disable iff (!rst_n)
        enable && off_code == 2'h0 |=> sink_on)
        else $error("sink not steady on with off time disabled");
    a_disabled_off: assert property (@(posedge clk) disable iff (!rst_n)
        !enable |=> !sink_on)
        else $error("disabled sink is on");
    a_on_phase_end: assert property (@(posedge clk) disable iff (!rst_n)
        enable && off_code != 2'h0 && state_q == ST_ON && tick && cnt_q + 11'd1 == on_len
        |=> state_q == ST_OFF)
        else $error("on phase did not end at on time");
    a_off_phase_end: assert property (@(posedge clk) disable iff (!rst_n)
        enable && off_code != 2'h0 && state_q == ST_OFF && tick && cnt_q + 11'd1 == off_len
        |=> state_q == ST_ON)
        else $error("off phase did not end at off time");
    a_on_phase_hold: assert property (@(posedge clk) disable iff (!rst_n)
        enable && state_q == ST_ON && !tick |=> state_q == ST_ON || !enable)
        else $error("on phase left without a tick");
endmodule : sink_blinker

/* File: verilog/led_sink_regs.sv */
// Purpose: dim current, fade law, sink enable and blink timing registers
// Assumes: register port driven by the serial front end on MCLK
// Notes: sinks one to four take their off times from the neighbouring bank
`timescale 1ns/1ps
module led_sink_regs #(
    parameter int TICK_COUNT = led_sink_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // register port
    input wire led_sink_pkg::reg_req_t REG_REQ,
    output logic [7:0] RD_DATA,
    // backlight dim
    input wire logic DIM_TIMEOUT,
    output logic [6:0] BL_DIM_CURRENT,
    output logic BL_DIM_ACTIVE,
    // independent sinks
    input wire logic [7:0] LOW_SINK_OFF_TIME,
    output led_sink_pkg::law_ctrl_t SINK_LAW,
    output logic [6:0] SINK_ON
);
    import led_sink_pkg::*;

    logic [6:0] dim_current_code_q;
    fade_law_t fade_law_select_q;
    logic [6:0] sink_enable_q;
    logic [1:0] blink_on_time_q;
    logic [1:0] sink_seven_off_time_q;
    logic [1:0] sink_six_off_time_q;
    logic [1:0] sink_five_off_time_q;
    logic [13:0] off_codes;
    logic [6:0] blink_on;
    logic tick;

    // ****************************************
    // register writes
    // ****************************************
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            dim_current_code_q <= DIM_CURRENT_RST[DIM_CODE_MSB:0];
            fade_law_select_q <= fade_law_t'(FADE_LAW_RST[LAW_MSB:0]);
            sink_enable_q <= SINK_ENABLE_RST[ENABLE_MSB:0];
            blink_on_time_q <= BLINK_TIME_RST[ON_TIME_LSB+:2];
            sink_seven_off_time_q <= BLINK_TIME_RST[SEVEN_OFF_LSB+:2];
            sink_six_off_time_q <= BLINK_TIME_RST[SIX_OFF_LSB+:2];
            sink_five_off_time_q <= BLINK_TIME_RST[FIVE_OFF_LSB+:2];
        end else if (REG_REQ.wr) begin
            case (REG_REQ.addr)
                ADDR_DIM_CURRENT: dim_current_code_q <= REG_REQ.wdata[DIM_CODE_MSB:0];
                ADDR_FADE_LAW: fade_law_select_q <= fade_law_t'(REG_REQ.wdata[LAW_MSB:0]);
                ADDR_SINK_ENABLE: sink_enable_q <= REG_REQ.wdata[ENABLE_MSB:0];
                ADDR_BLINK_TIME_A: begin
                    blink_on_time_q <= REG_REQ.wdata[ON_TIME_LSB+:2];
                    sink_seven_off_time_q <= REG_REQ.wdata[SEVEN_OFF_LSB+:2];
                    sink_six_off_time_q <= REG_REQ.wdata[SIX_OFF_LSB+:2];
                    sink_five_off_time_q <= REG_REQ.wdata[FIVE_OFF_LSB+:2];
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // register reads
    // ****************************************
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            RD_DATA <= 8'h00;
        end else if (REG_REQ.rd) begin
            case (REG_REQ.addr)
                ADDR_DIM_CURRENT: RD_DATA <= {1'b0, dim_current_code_q};
                ADDR_FADE_LAW: RD_DATA <= {6'h00, fade_law_select_q};
                ADDR_SINK_ENABLE: RD_DATA <= {1'b0, sink_enable_q};
                ADDR_BLINK_TIME_A: RD_DATA <= {blink_on_time_q, sink_seven_off_time_q,
                    sink_six_off_time_q, sink_five_off_time_q};
                default: RD_DATA <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // backlight dim current
    // ****************************************
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            BL_DIM_CURRENT <= 7'h00;
            BL_DIM_ACTIVE <= 1'b0;
        end else begin
            BL_DIM_CURRENT <= DIM_TIMEOUT ? dim_current_code_q : 7'h00;
            BL_DIM_ACTIVE <= DIM_TIMEOUT;
        end
    end

    // ****************************************
    // fade transfer law decode
    // ****************************************
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            SINK_LAW <= '0;
        end else begin
            SINK_LAW.square_dac <= (fade_law_select_q != LAW_LINEAR);
            SINK_LAW.nonlinear_step <= (fade_law_select_q == LAW_CUBIC_10) ||
                (fade_law_select_q == LAW_CUBIC_11);
            SINK_LAW.cubic_variant <= (fade_law_select_q == LAW_CUBIC_11);
        end
    end

    // ****************************************
    // blink sequencing
    // ****************************************
    tick_divider #(
        .COUNT(TICK_COUNT)
    ) u_tick (
        .clk(MCLK),
        .rst_n(RESETN),
        .tick(tick)
    );

    assign off_codes = {sink_seven_off_time_q, sink_six_off_time_q, sink_five_off_time_q,
        LOW_SINK_OFF_TIME};

    for (genvar i = 0; i < NUM_SINKS; i++) begin : g_sink
        sink_blinker u_blink (
            .clk(MCLK),
            .rst_n(RESETN),
            .tick(tick),
            .enable(sink_enable_q[i]),
            .on_code(blink_on_time_q),
            .off_code(off_codes[2*i+:2]),
            .sink_on(blink_on[i])
        );
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            SINK_ON <= 7'h00;
        end else begin
            SINK_ON <= blink_on & sink_enable_q;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_dim_code_applied: assert property (@(posedge MCLK) disable iff (!RESETN)
        DIM_TIMEOUT |=> BL_DIM_CURRENT == $past(dim_current_code_q) && BL_DIM_ACTIVE)
        else $error("dim code not applied after timeout");
    a_law_reserved_zero: assert property (@(posedge MCLK) disable iff (!RESETN)
        REG_REQ.rd && REG_REQ.addr == ADDR_FADE_LAW |=> RD_DATA[7:2] == 6'h00)
        else $error("fade law reserved bits not zero");
    a_linear_law_dac: assert property (@(posedge MCLK) disable iff (!RESETN)
        fade_law_select_q == LAW_LINEAR |=> !SINK_LAW.square_dac && !SINK_LAW.nonlinear_step)
        else $error("linear law decoded wrong");
    a_cubic_square_dac: assert property (@(posedge MCLK) disable iff (!RESETN)
        fade_law_select_q == LAW_CUBIC_10 || fade_law_select_q == LAW_CUBIC_11
        |=> SINK_LAW.square_dac && SINK_LAW.nonlinear_step)
        else $error("cubic law lost square dac");
    a_square_law_dac: assert property (@(posedge MCLK) disable iff (!RESETN)
        fade_law_select_q == LAW_SQUARE |=> SINK_LAW.square_dac && !SINK_LAW.nonlinear_step)
        else $error("square law decoded wrong");
    a_cubic_variant_sel: assert property (@(posedge MCLK) disable iff (!RESETN)
        fade_law_select_q == LAW_CUBIC_11 |=> SINK_LAW.cubic_variant)
        else $error("second cubic variant not flagged");
    a_cubic_ten_sel: assert property (@(posedge MCLK) disable iff (!RESETN)
        fade_law_select_q == LAW_CUBIC_10 |=> !SINK_LAW.cubic_variant)
        else $error("first cubic variant flagged as second");
    a_law_write: assert property (@(posedge MCLK) disable iff (!RESETN)
        REG_REQ.wr && REG_REQ.addr == ADDR_FADE_LAW
        |=> 2'(fade_law_select_q) == $past(REG_REQ.wdata[1:0]))
        else $error("fade law write not stored");
    a_dim_idle_zero: assert property (@(posedge MCLK) disable iff (!RESETN)
        !DIM_TIMEOUT |=> BL_DIM_CURRENT == 7'h00 && !BL_DIM_ACTIVE)
        else $error("dim current driven without timeout");
    a_dim_code_write: assert property (@(posedge MCLK) disable iff (!RESETN)
        REG_REQ.wr && REG_REQ.addr == ADDR_DIM_CURRENT
        |=> dim_current_code_q == $past(REG_REQ.wdata[6:0]))
        else $error("dim code write not stored");
    a_dim_code_read: assert property (@(posedge MCLK) disable iff (!RESETN)
        REG_REQ.rd && REG_REQ.addr == ADDR_DIM_CURRENT
        |=> RD_DATA == {1'h0, $past(dim_current_code_q)})
        else $error("dim code read wrong");
    a_enable_read: assert property (@(posedge MCLK) disable iff (!RESETN)
        REG_REQ.rd && REG_REQ.addr == ADDR_SINK_ENABLE
        |=> RD_DATA == {1'h0, $past(sink_enable_q)})
        else $error("enable read wrong");
    a_sink_gated_off: assert property (@(posedge MCLK) disable iff (!RESETN)
        1'h1 |=> (SINK_ON & ~$past(sink_enable_q)) == 7'h00)
        else $error("sink on while its enable is clear");
    a_time_read: assert property (@(posedge MCLK) disable iff (!RESETN)
        REG_REQ.rd && REG_REQ.addr == ADDR_BLINK_TIME_A
        |=> RD_DATA == {$past(blink_on_time_q), $past(sink_seven_off_time_q),
            $past(sink_six_off_time_q), $past(sink_five_off_time_q)})
        else $error("timing read wrong");
    a_low_off_write: assert property (@(posedge MCLK) disable iff (!RESETN)
        REG_REQ.wr && REG_REQ.addr == ADDR_BLINK_TIME_A
        |=> sink_six_off_time_q == $past(REG_REQ.wdata[3:2])
            && sink_five_off_time_q == $past(REG_REQ.wdata[1:0]))
        else $error("sink six or five off time not stored");
    a_enable_write: assert property (@(posedge MCLK) disable iff (!RESETN)
        REG_REQ.wr && REG_REQ.addr == ADDR_SINK_ENABLE
        |=> sink_enable_q == $past(REG_REQ.wdata[6:0]))
        else $error("enable write not stored");
    a_seven_off_write: assert property (@(posedge MCLK) disable iff (!RESETN)
        REG_REQ.wr && REG_REQ.addr == ADDR_BLINK_TIME_A
        |=> sink_seven_off_time_q == $past(REG_REQ.wdata[5:4])
            && blink_on_time_q == $past(REG_REQ.wdata[7:6]))
        else $error("timing write not stored");
    a_steady_sink_on: assert property (@(posedge MCLK) disable iff (!RESETN)
        sink_enable_q[6] && sink_seven_off_time_q == 2'h0 ##1
        sink_enable_q[6] && sink_seven_off_time_q == 2'h0 |=> SINK_ON[6])
        else $error("sink seven not steady on");
endmodule : led_sink_regs

/* File: verification/host_model.sv */
// Purpose: host side of the register port, byte writes and reads
// Assumes: requests launched on the falling edge of clk
// Notes: one idle cycle follows every request
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic clk,
    // register port
    output led_sink_pkg::reg_req_t req,
    input wire logic [7:0] rd_data
);
    import led_sink_pkg::*;

    initial req = '0;

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge clk);
        req <= '0;
    endtask : write_reg

    // read data is registered at the request edge, so it is settled by the next fall
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge clk);
        req <= '0;
        data = rd_data;
    endtask : read_reg

endmodule : host_model

/* File: verification/test_led_sink_blink_dim_registers.sv */
// Purpose: self-checking bench for the LED sink register bank
// Assumes: one blink tick every 4 clocks
// Notes: blink phase lengths are checked with two ticks of slack below and one tick above
`timescale 1ns/1ps
module test_led_sink_blink_dim_registers;
    import led_sink_pkg::*;

    localparam int TICK = 4;

    logic mclk = 1'b0;
    logic resetn = 1'b0;
    reg_req_t reg_req;
    logic [7:0] rd_data;
    logic dim_timeout = 1'b0;
    logic [6:0] bl_dim_current;
    logic bl_dim_active;
    logic [7:0] low_sink_off_time = 8'h00;
    law_ctrl_t sink_law;
    logic [6:0] sink_on;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [7:0] got;
    logic [23:0] rows [5] = '{24'h0AFF7F, 24'h0FFF03, 24'h10FF7F, 24'h11A5A5, 24'h42FF00};
    int on_ms_tab [4] = '{200, 600, 800, 1200};

    always #2 mclk = ~mclk;

    led_sink_regs #(.TICK_COUNT(TICK)) i_dut (
        .MCLK(mclk),
        .RESETN(resetn),
        .REG_REQ(reg_req),
        .RD_DATA(rd_data),
        .DIM_TIMEOUT(dim_timeout),
        .BL_DIM_CURRENT(bl_dim_current),
        .BL_DIM_ACTIVE(bl_dim_active),
        .LOW_SINK_OFF_TIME(low_sink_off_time),
        .SINK_LAW(sink_law),
        .SINK_ON(sink_on)
    );

    host_model i_host (
        .clk(mclk),
        .req(reg_req),
        .rd_data(rd_data)
    );

    task automatic final_report();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check_val

    task automatic check_range(input string name, input int lo, input int hi, input int seen);
        tests_run++;
        if (seen < lo || seen > hi) begin
            miscompares++;
            $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, seen);
        end
    endtask : check_range

    // counts cycles for which one sink holds a level, stopping at hi + 1
    task automatic phase_len(input int b, input logic lvl, input int hi, output int n);
        n = 0;
        while (sink_on[b] === lvl && n <= hi) begin
            @(negedge mclk);
            n++;
        end
    endtask : phase_len

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        int n;
        int on_len;
        int off_len;
        logic [1:0] c;
        logic bad;
        // ****************************************
        // reset
        // ****************************************
        repeat (12) @(negedge mclk);
        check_val("sink_on in reset", 8'h00, {1'b0, sink_on});
        check_val("dim in reset", 8'h00, {bl_dim_active, bl_dim_current});
        resetn = 1'b1;
        i_host.read_reg(ADDR_SINK_ENABLE, got);
        check_val("enable reset", 8'h00, got);
        i_host.read_reg(ADDR_BLINK_TIME_A, got);
        check_val("time reset", 8'h00, got);
        // ****************************************
        // register rows
        // ****************************************
        foreach (rows[i]) begin
            i_host.write_reg(rows[i][23:16], rows[i][15:8]);
            i_host.read_reg(rows[i][23:16], got);
            check_val("readback", rows[i][7:0], got);
        end
        i_host.write_reg(ADDR_SINK_ENABLE, 8'h00);
        // dim code follows the timeout one cycle later
        dim_timeout = 1'b1;
        @(negedge mclk);
        @(negedge mclk);
        check_val("dim current", 8'hFF, {bl_dim_active, bl_dim_current});
        dim_timeout = 1'b0;
        @(negedge mclk);
        @(negedge mclk);
        check_val("dim idle", 8'h00, {bl_dim_active, bl_dim_current});
        for (int l = 0; l < 4; l++) begin
            i_host.write_reg(ADDR_FADE_LAW, 8'(l));
            repeat (2) @(negedge mclk);
            check_val("law", {5'h00, l != 0, l >= 2, l == 3}, {5'h00, sink_law});
        end
        // ****************************************
        // steady on with off time disabled
        // ****************************************
        i_host.write_reg(ADDR_BLINK_TIME_A, 8'hC0);
        i_host.write_reg(ADDR_SINK_ENABLE, 8'h7F);
        repeat (3) @(negedge mclk);
        bad = 1'b0;
        repeat (5000) begin
            @(negedge mclk);
            if (sink_on !== 7'h7F) bad = 1'b1;
        end
        check_val("steady", 8'h00, {7'h00, bad});
        i_host.write_reg(ADDR_SINK_ENABLE, 8'h00);
        repeat (3) @(negedge mclk);
        check_val("all off", 8'h00, {1'b0, sink_on});
        // ****************************************
        // blink timing for each on code
        // ****************************************
        for (int k = 0; k < 4; k++) begin
            c = (k == 0) ? 2'h1 : 2'(k);
            i_host.write_reg(ADDR_BLINK_TIME_A, {2'(k), 4'h0, c});
            i_host.write_reg(ADDR_SINK_ENABLE, 8'h10);
            repeat (3) @(negedge mclk);
            check_val("blink start", 8'h10, {1'b0, sink_on});
            on_len = on_ms_tab[k] * TICK;
            off_len = 600 * c * TICK;
            phase_len(4, 1'b1, on_len + 8, n);
            check_range("on phase", on_len - 2 * TICK, on_len + 4, n);
            phase_len(4, 1'b0, off_len + 8, n);
            check_range("off phase", off_len - TICK - 4, off_len + 4, n);
            check_val("on again", 8'h10, {1'b0, sink_on});
            i_host.write_reg(ADDR_SINK_ENABLE, 8'h00);
            repeat (3) @(negedge mclk);
            check_val("disabled", 8'h00, {1'b0, sink_on});
        end
        // sinks six and four blink in step; sink four takes its off time from the low port
        low_sink_off_time = 8'h40;
        i_host.write_reg(ADDR_BLINK_TIME_A, 8'h04);
        i_host.write_reg(ADDR_SINK_ENABLE, 8'h28);
        repeat (3) @(negedge mclk);
        phase_len(5, 1'b1, 808, n);
        check_val("both off", 8'h00, {1'b0, sink_on});
        phase_len(5, 1'b0, 2408, n);
        check_range("six off", 2400 - TICK - 4, 2404, n);
        check_val("both on", 8'h28, {1'b0, sink_on});
        phase_len(5, 1'b1, 808, n);
        check_range("six on", 800 - 2 * TICK, 804, n);
        // off code cleared in the off phase: sink six turns on, sink four stays off
        i_host.write_reg(ADDR_BLINK_TIME_A, 8'h00);
        repeat (3) @(negedge mclk);
        check_val("forced on", 8'h20, {1'b0, sink_on});
        // sink seven uses the top off field
        i_host.write_reg(ADDR_BLINK_TIME_A, 8'h30);
        i_host.write_reg(ADDR_SINK_ENABLE, 8'h40);
        repeat (3) @(negedge mclk);
        phase_len(6, 1'b1, 808, n);
        phase_len(6, 1'b0, 7208, n);
        check_range("seven off", 7200 - TICK - 4, 7204, n);
        // reset in mid-run while sink seven blinks
        resetn = 1'b0;
        repeat (2) @(negedge mclk);
        check_val("sink_on mid reset", 8'h00, {1'b0, sink_on});
        resetn = 1'b1;
        i_host.read_reg(ADDR_SINK_ENABLE, got);
        check_val("enable after reset", 8'h00, got);
        i_host.read_reg(ADDR_BLINK_TIME_A, got);
        check_val("time after reset", 8'h00, got);
        final_report();
    end

endmodule : test_led_sink_blink_dim_registers
